// *** tb/baro_ctrl_monitor.sv ***
`timescale 1ns/10ps
`default_nettype none
module baro_ctrl_monitor (
  // Clock, reset and register bus
  input wire logic clock,
  input wire logic arst_n,
  input wire baro_ctrl_pkg::reg_req_t reg_req,
  input wire logic rd_valid,
  // Engines and strobes
  input wire logic rate_tick,
  input wire logic trim_copy,
  input wire logic trim_copy_done,
  input wire logic conv_start,
  input wire logic conv_done,
  input wire logic results_latch,
  input wire logic continuous_mode,
  input wire logic fifo_flush
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  // Decoded writes to the two control registers
  wire logic c2_w = reg_req.wr && reg_req.addr == 8'h11;
  wire logic trig_w = c2_w && reg_req.wdata[0] && !reg_req.wdata[2];
  wire logic rst_w = c2_w && reg_req.wdata[2];
  wire logic rate_w = reg_req.wr && reg_req.addr == 8'h10;
  logic busy_r; // Conversion in flight
  logic retrig_r; // Trigger seen while converting
  logic armed_r; // Reload requested, copy not yet begun
  // Tracking state, so the rules can name their cause
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      busy_r <= 1'b0;
      retrig_r <= 1'b0;
      armed_r <= 1'b0;
    end else begin
      busy_r <= conv_start || (busy_r && !conv_done);
      retrig_r <= (trig_w && busy_r) || (retrig_r && !conv_done);
      armed_r <= (c2_w && reg_req.wdata[7]) || (armed_r && !trim_copy);
    end
  end
  sequence start_walk;
    ##2 conv_start;
  endsequence
  // Flush is one pulse, two cycles after the request
  sequence flush_walk;
    ##1 !fifo_flush ##1 fifo_flush ##1 !fifo_flush;
  endsequence
  a_power_up_copy: assert property ($rose(arst_n) |=> trim_copy)
    else $error("no trim copy after power-up");
  a_reload_waits_tick: assert property
    (armed_r && !trim_copy && !rate_tick |=> !trim_copy)
    else $error("trim reload began without a rate tick");
  a_copy_ends_done: assert property
    (trim_copy |=> trim_copy == !$past(trim_copy_done))
    else $error("trim copy did not end at its done");
  a_reset_flushes: assert property (rst_w |-> flush_walk)
    else $error("soft reset gave no single flush");
  a_trigger_starts: assert property
    (trig_w && !continuous_mode && !busy_r |-> start_walk)
    else $error("trigger did not start a conversion");
  a_trigger_ignored: assert property
    (trig_w && continuous_mode && !busy_r |=> !conv_start [*2])
    else $error("trigger acted in continuous mode");
  a_done_latches: assert property
    (conv_done && busy_r |=> results_latch)
    else $error("no results latch after done");
  a_retrigger_runs: assert property
    (conv_done && retrig_r |=> conv_start && results_latch)
    else $error("retrigger did not start next conversion");
  a_rate_mode: assert property
    (rate_w ##1 !rate_w |=> continuous_mode ==
      ($past(reg_req.wdata[6:4], 2) != 3'h0))
    else $error("continuous mode does not follow rate select");
  a_read_answer: assert property (reg_req.rd |=> rd_valid)
    else $error("read not answered");
endmodule : baro_ctrl_monitor
bind sensor_boot_reset_oneshot_ctrl baro_ctrl_monitor u_baro_ctrl_monitor (
  .clock(clock),
  .arst_n(arst_n),
  .reg_req(reg_req),
  .rd_valid(rd_valid),
  .rate_tick(rate_tick),
  .trim_copy(trim_copy),
  .trim_copy_done(trim_copy_done),
  .conv_start(conv_start),
  .conv_done(conv_done),
  .results_latch(results_latch),
  .continuous_mode(continuous_mode),
  .fifo_flush(fifo_flush)
);
`default_nettype wire

// *** tb/baro_engine_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// Trim copy and conversion engines with a free running rate timebase
module baro_engine_model (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic slow,
  input wire logic trim_copy,
  input wire logic conv_start,
  output logic trim_copy_done,
  output logic conv_done,
  output logic rate_tick
);
  logic [2:0] tick_r; // Rate period counter
  logic [3:0] tc_r; // Copy progress
  logic [3:0] cc_r; // Conversion progress
  logic run_r; // Conversion under way
  // Slow mode stretches a conversion so a retrigger can land inside it
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      {tick_r, tc_r, cc_r, run_r} <= '0;
      {trim_copy_done, conv_done, rate_tick} <= '0;
    end else begin
      tick_r <= tick_r + 3'h1;
      rate_tick <= tick_r == 3'h7;
      tc_r <= trim_copy ? tc_r + 4'h1 : 4'h0;
      trim_copy_done <= trim_copy && tc_r == 4'h3;
      cc_r <= conv_start ? 4'h0 : cc_r + 4'h1;
      run_r <= conv_start || (run_r && !conv_done);
      conv_done <= run_r && cc_r == (slow ? 4'hb : 4'h2) && !conv_done;
    end
  end
endmodule : baro_engine_model
`default_nettype wire

// *** tb/sensor_boot_reset_oneshot_ctrl_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module sensor_boot_reset_oneshot_ctrl_tb;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic slow = 1'b0;
  baro_ctrl_pkg::reg_req_t req = '0;
  logic [7:0] rd_data, d;
  logic rd_valid, rate_tick, trim_copy, trim_copy_done, conv_start;
  logic conv_done, results_latch, continuous_mode, fifo_flush;
  logic [7:0] n_start = 8'h00; // Strobe counts
  logic [7:0] n_latch = 8'h00;
  logic [7:0] n_flush = 8'h00;
  logic [7:0] s0, s1;
  logic [31:0] seed = 32'h5fcb7805;
  int mismatches = 0;
  int num_checks = 0;
  logic [7:0] regs [10] = '{8'h0b, 8'h0c, 8'h0d, 8'h10, 8'h11, 8'h12,
    8'h14, 8'h15, 8'h16, 8'h17};
  // Free running clock, 4 ns period
  always #2 clock = ~clock;
  sensor_boot_reset_oneshot_ctrl u_sensor_boot_reset_oneshot_ctrl (
    .clock(clock), .arst_n(arst_n), .reg_req(req), .rd_data(rd_data),
    .rd_valid(rd_valid), .rate_tick(rate_tick), .trim_copy(trim_copy),
    .trim_copy_done(trim_copy_done), .conv_start(conv_start),
    .conv_done(conv_done), .results_latch(results_latch),
    .continuous_mode(continuous_mode), .fifo_flush(fifo_flush));
  baro_engine_model u_baro_engine_model (.clock(clock), .arst_n(arst_n),
    .slow(slow), .trim_copy(trim_copy), .conv_start(conv_start),
    .trim_copy_done(trim_copy_done), .conv_done(conv_done),
    .rate_tick(rate_tick));
  // Count one-cycle strobes so no pulse is missed between checks
  always @(posedge clock) begin
    n_start <= n_start + 8'(conv_start);
    n_latch <= n_latch + 8'(results_latch);
    n_flush <= n_flush + 8'(fifo_flush);
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  // Defaults: control_two holds 0x10, all others zero
  function automatic logic [7:0] dflt(input logic [7:0] a);
    return a == 8'h11 ? 8'h10 : 8'h00;
  endfunction : dflt
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input string n, input logic [8:0] e, input logic [8:0] s);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    req <= '{1'b1, 1'b0, a, v};
    @(posedge clock);
    req <= '0;
  endtask : wr
  // Read lands one cycle later, sampled once settled
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clock);
    req <= '0;
    #1 chk("read", {1'b1, e}, {rd_valid, rd_data});
  endtask : rchk
  // Bounded wait; k 0 watches trim_copy, else results_latch
  task automatic wait_sig(input int k, input logic lvl);
    int i;
    for (i = 0; i < 300 && (k == 0 ? trim_copy : results_latch) !== lvl; i++)
      @(posedge clock);
    if (i == 300) begin
      mismatches++;
      $display("unexpected timeout expected %h seen %h", lvl, ~lvl);
      print_verdict;
    end
  endtask : wait_sig
  initial begin
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    wait_sig(0, 1'b1);
    wait_sig(0, 1'b0);
    foreach (regs[i]) rchk(regs[i], dflt(regs[i]));
    rchk(8'h0e, 8'h00);
    foreach (regs[i]) if (regs[i] != 8'h10 && regs[i] != 8'h11) begin
      seed = xs(seed);
      wr(regs[i], seed[7:0]);
      rchk(regs[i], seed[7:0]);
    end
    s0 = n_flush;
    wr(8'h11, 8'h14);
    foreach (regs[i]) rchk(regs[i], dflt(regs[i]));
    chk("flush", 9'(s0 + 8'h01), 9'(n_flush));
    wr(8'h11, 8'h90);
    wait_sig(0, 1'b1);
    wait_sig(0, 1'b0);
    rchk(8'h11, 8'h10);
    // Slow conversion, retrigger lands inside it
    slow <= 1'b1;
    s0 = n_start;
    s1 = n_latch;
    wr(8'h11, 8'h11);
    repeat (3) @(posedge clock);
    wr(8'h11, 8'h11);
    wait_sig(1, 1'b1);
    @(posedge clock);
    wait_sig(1, 1'b1);
    rchk(8'h11, 8'h10);
    chk("starts", 9'(s0 + 8'h02), 9'(n_start));
    chk("latches", 9'(s1 + 8'h02), 9'(n_latch));
    seed = xs(seed);
    d = seed[7:0] | 8'h10;
    wr(8'h10, d);
    rchk(8'h10, d);
    chk("continuous", 9'h001, 9'(continuous_mode));
    s0 = n_start;
    wr(8'h11, 8'h11);
    rchk(8'h11, 8'h10);
    rchk(8'h10, d);
    chk("starts", 9'(s0), 9'(n_start));
    wr(8'h10, 8'h00);
    rchk(8'h10, 8'h00);
    chk("continuous", 9'h000, 9'(continuous_mode));
    print_verdict;
  end
endmodule : sensor_boot_reset_oneshot_ctrl_tb
`default_nettype wire

// *** verilog/baro_ctrl_pkg.sv ***
`default_nettype none
package baro_ctrl_pkg;
  // Register offsets
  localparam logic [7:0] OFS_INT_CFG = 8'h0b;
  localparam logic [7:0] OFS_THS_L = 8'h0c;
  localparam logic [7:0] OFS_THS_H = 8'h0d;
  localparam logic [7:0] OFS_CTRL1 = 8'h10;
  localparam logic [7:0] OFS_CTRL2 = 8'h11;
  localparam logic [7:0] OFS_CTRL3 = 8'h12;
  localparam logic [7:0] OFS_FIFO = 8'h14;
  localparam logic [7:0] OFS_REF_XL = 8'h15;
  localparam logic [7:0] OFS_REF_L = 8'h16;
  localparam logic [7:0] OFS_REF_H = 8'h17;
  // Number of mapped registers and their slot index
  localparam int NREG = 10;
  localparam logic [3:0] IDX_CTRL1 = 4'h3;
  localparam logic [3:0] IDX_CTRL2 = 4'h4;
  // Reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_CTRL2 = 8'h10;
  // Field positions in control_two
  localparam int BIT_BOOT = 7;
  localparam int BIT_SOFT_RST = 2;
  localparam int BIT_RSVD = 1;
  localparam int BIT_ONE_SHOT = 0;
  // Output rate select field in control_one
  localparam int RATE_LSB = 4;
  localparam int RATE_W = 3;
  localparam logic [2:0] RATE_IDLE = 3'h0;
  // Register access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
  // Trim engine and conversion states
  typedef enum logic [1:0] {B_IDLE, B_WAIT, B_COPY} boot_state_t;
  typedef enum logic {C_IDLE, C_RUN} conv_state_t;
endpackage : baro_ctrl_pkg
`default_nettype wire

// *** verilog/sensor_boot_reset_oneshot_ctrl.sv ***
`timescale 1ns/10ps
`default_nettype none

module sensor_boot_reset_oneshot_ctrl (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Register access from the serial front end
  input wire baro_ctrl_pkg::reg_req_t reg_req,
  output logic [7:0] rd_data,
  output logic rd_valid,
  // Output data rate timebase, one pulse per rate period
  input wire logic rate_tick,
  // Trim storage copy engine
  output logic trim_copy,
  input wire logic trim_copy_done,
  // Conversion engine
  output logic conv_start,
  input wire logic conv_done,
  output logic results_latch,
  output logic continuous_mode,
  // FIFO flush
  output logic fifo_flush
);

  // Register slots in map order
  logic [7:0] regs_r [baro_ctrl_pkg::NREG];
  logic [7:0] regs_nxt [baro_ctrl_pkg::NREG];
  // Read answer
  logic [7:0] rd_data_r, rd_data_nxt;
  logic rd_valid_r, rd_valid_nxt;
  // Trim engine
  baro_ctrl_pkg::boot_state_t boot_r, boot_nxt;
  logic pwrup_r, pwrup_nxt; // Power-up copy still owed
  logic trim_copy_r, trim_copy_nxt;
  // Conversion control
  baro_ctrl_pkg::conv_state_t conv_r, conv_nxt;
  logic again_r, again_nxt; // Trigger seen mid-run
  logic conv_start_r, conv_start_nxt;
  logic latch_r, latch_nxt;
  logic cont_r, cont_nxt;
  // Soft reset
  logic flush_r, flush_nxt;

  // Map an offset onto a slot; valid flags mapped offsets
  function automatic logic [4:0] slot_of(input logic [7:0] a);
    logic [4:0] s;
    s = 5'h00;
    unique case (a)
      baro_ctrl_pkg::OFS_INT_CFG: s = 5'h10;
      baro_ctrl_pkg::OFS_THS_L: s = 5'h11;
      baro_ctrl_pkg::OFS_THS_H: s = 5'h12;
      baro_ctrl_pkg::OFS_CTRL1: s = 5'h13;
      baro_ctrl_pkg::OFS_CTRL2: s = 5'h14;
      baro_ctrl_pkg::OFS_CTRL3: s = 5'h15;
      baro_ctrl_pkg::OFS_FIFO: s = 5'h16;
      baro_ctrl_pkg::OFS_REF_XL: s = 5'h17;
      baro_ctrl_pkg::OFS_REF_L: s = 5'h18;
      baro_ctrl_pkg::OFS_REF_H: s = 5'h19;
      // Unmapped offsets keep the map flag clear
      default: s = 5'h00;
    endcase
    return s;
  endfunction : slot_of

  // Default value of each slot
  function automatic logic [7:0] dflt(input int i);
    logic [7:0] v;
    v = baro_ctrl_pkg::RST_ZERO;
    if (i == int'(baro_ctrl_pkg::IDX_CTRL2)) begin
      v = baro_ctrl_pkg::RST_CTRL2;
    end
    return v;
  endfunction : dflt

  logic [4:0] wslot; // Slot code, top bit marks a mapped offset
  logic [3:0] widx; // Slot index into the register file
  logic wmap; // Offset is one of the mapped registers
  logic [2:0] rate_sel; // Output rate select of control_one
  logic [7:0] c2; // Current control_two contents
  logic c2_wr; // Write to control_two that will be kept
  logic trig_wr; // Trigger write that may start or queue a run

  // Decode of the current access
  always_comb begin
    wslot = slot_of(reg_req.addr);
    wmap = wslot[4];
    widx = wslot[3:0];
    rate_sel = regs_r[baro_ctrl_pkg::IDX_CTRL1]
      [baro_ctrl_pkg::RATE_LSB +: baro_ctrl_pkg::RATE_W];
    c2 = regs_r[baro_ctrl_pkg::IDX_CTRL2];
    // A write in the cycle that restores defaults is lost, so it
    // must not hold back a hardware clear either
    c2_wr = reg_req.wr && wmap && (widx == baro_ctrl_pkg::IDX_CTRL2) &&
      !c2[baro_ctrl_pkg::BIT_SOFT_RST];
    // Trigger writes count only while the rate select is idle
    trig_wr = c2_wr && reg_req.wdata[baro_ctrl_pkg::BIT_ONE_SHOT] &&
      rate_sel == baro_ctrl_pkg::RATE_IDLE;
  end

  // Register file next state, with self-clearing bits
  always_comb begin
    logic [7:0] w;
    w = reg_req.wdata;
    for (int i = 0; i < baro_ctrl_pkg::NREG; i++) begin
      regs_nxt[i] = regs_r[i];
    end
    flush_nxt = 1'b0;
    if (c2[baro_ctrl_pkg::BIT_SOFT_RST]) begin
      // Request seen last cycle: restore defaults, which also drops
      // the request bit, and empty the FIFO in the same cycle
      for (int i = 0; i < baro_ctrl_pkg::NREG; i++) begin
        regs_nxt[i] = dflt(i);
      end
      flush_nxt = 1'b1;
      // Keep reload and trigger state running across the reset
      regs_nxt[baro_ctrl_pkg::IDX_CTRL2][baro_ctrl_pkg::BIT_BOOT] =
        c2[baro_ctrl_pkg::BIT_BOOT];
      regs_nxt[baro_ctrl_pkg::IDX_CTRL2][baro_ctrl_pkg::BIT_ONE_SHOT] =
        c2[baro_ctrl_pkg::BIT_ONE_SHOT];
    end else if (reg_req.wr && wmap) begin
      if (c2_wr) begin
        // Self-clearing bits are only set by software, never cleared
        w[baro_ctrl_pkg::BIT_BOOT] = w[baro_ctrl_pkg::BIT_BOOT] |
          c2[baro_ctrl_pkg::BIT_BOOT];
        // Trigger is only stored while the rate is idle
        w[baro_ctrl_pkg::BIT_ONE_SHOT] = c2[baro_ctrl_pkg::BIT_ONE_SHOT] |
          (w[baro_ctrl_pkg::BIT_ONE_SHOT] &&
           rate_sel == baro_ctrl_pkg::RATE_IDLE);
        // Reserved bit is stored as written; the host keeps it zero
        w[baro_ctrl_pkg::BIT_RSVD] = w[baro_ctrl_pkg::BIT_RSVD];
      end
      regs_nxt[widx] = w;
    end
    // Hardware clears; a set in the same cycle wins
    if (boot_r == baro_ctrl_pkg::B_COPY && trim_copy_done && !pwrup_r &&
        !(c2_wr && reg_req.wdata[baro_ctrl_pkg::BIT_BOOT])) begin
      regs_nxt[baro_ctrl_pkg::IDX_CTRL2][baro_ctrl_pkg::BIT_BOOT] =
        1'b0;
    end
    if (conv_r == baro_ctrl_pkg::C_RUN && conv_done && !again_r &&
        !trig_wr) begin
      regs_nxt[baro_ctrl_pkg::IDX_CTRL2][baro_ctrl_pkg::BIT_ONE_SHOT] =
        1'b0;
    end
  end

  // Registers take their defaults at reset
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < baro_ctrl_pkg::NREG; i++) begin
        regs_r[i] <= dflt(i);
      end
      flush_r <= 1'b0;
    end else begin
      regs_r <= regs_nxt;
      flush_r <= flush_nxt;
    end
  end

  // Read path; unmapped offsets answer zero
  always_comb begin
    rd_valid_nxt = reg_req.rd;
    rd_data_nxt = rd_data_r;
    if (reg_req.rd) begin
      rd_data_nxt = wmap ? regs_r[widx] : 8'h00;
    end
  end

  // Read answer registers; data holds between reads
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rd_data_r <= 8'h00;
      rd_valid_r <= 1'b0;
    end else begin
      rd_data_r <= rd_data_nxt;
      rd_valid_r <= rd_valid_nxt;
    end
  end

  // Trim engine: power-up copy at once, reload after one rate tick
  always_comb begin
    boot_nxt = boot_r;
    pwrup_nxt = pwrup_r;
    trim_copy_nxt = 1'b0;
    unique case (boot_r)
      baro_ctrl_pkg::B_IDLE: begin
        if (pwrup_r) begin
          boot_nxt = baro_ctrl_pkg::B_COPY;
          trim_copy_nxt = 1'b1;
        end else if (c2[baro_ctrl_pkg::BIT_BOOT]) begin
          boot_nxt = baro_ctrl_pkg::B_WAIT;
        end
      end
      baro_ctrl_pkg::B_WAIT: begin
        // Copy starts only when the rate timebase has ticked
        if (rate_tick) begin
          boot_nxt = baro_ctrl_pkg::B_COPY;
          trim_copy_nxt = 1'b1;
        end
      end
      baro_ctrl_pkg::B_COPY: begin
        // Hold the copy request until the engine reports done
        trim_copy_nxt = 1'b1;
        if (trim_copy_done) begin
          boot_nxt = baro_ctrl_pkg::B_IDLE;
          trim_copy_nxt = 1'b0;
          pwrup_nxt = 1'b0;
        end
      end
      default: boot_nxt = baro_ctrl_pkg::B_IDLE;
    endcase
  end

  // Trim engine registers; power-up copy is owed after every arst_n reset, not after a soft reset
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      boot_r <= baro_ctrl_pkg::B_IDLE;
      pwrup_r <= 1'b1;
      trim_copy_r <= 1'b0;
    end else begin
      boot_r <= boot_nxt;
      pwrup_r <= pwrup_nxt;
      trim_copy_r <= trim_copy_nxt;
    end
  end

  // Single conversion control
  always_comb begin
    conv_nxt = conv_r;
    again_nxt = again_r;
    conv_start_nxt = 1'b0;
    latch_nxt = 1'b0;
    cont_nxt = (rate_sel != baro_ctrl_pkg::RATE_IDLE);
    unique case (conv_r)
      baro_ctrl_pkg::C_IDLE: begin
        // A stored trigger at idle rate starts one run
        if (c2[baro_ctrl_pkg::BIT_ONE_SHOT] &&
            rate_sel == baro_ctrl_pkg::RATE_IDLE) begin
          conv_nxt = baro_ctrl_pkg::C_RUN;
          conv_start_nxt = 1'b1;
        end
      end
      baro_ctrl_pkg::C_RUN: begin
        // A new trigger during the run is remembered; one written
        // while the rate is running is dropped, not queued
        if (trig_wr) begin
          again_nxt = 1'b1;
        end
        // Results move out whether or not another run follows
        if (conv_done) begin
          latch_nxt = 1'b1;
          if (again_r || again_nxt) begin
            conv_start_nxt = 1'b1;
            again_nxt = 1'b0;
          end else begin
            conv_nxt = baro_ctrl_pkg::C_IDLE;
          end
        end
      end
    endcase
  end

  // Conversion control registers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      conv_r <= baro_ctrl_pkg::C_IDLE;
      again_r <= 1'b0;
      conv_start_r <= 1'b0;
      latch_r <= 1'b0;
      cont_r <= 1'b0;
    end else begin
      conv_r <= conv_nxt;
      again_r <= again_nxt;
      conv_start_r <= conv_start_nxt;
      latch_r <= latch_nxt;
      cont_r <= cont_nxt;
    end
  end

  // Outputs straight from flops
  assign rd_data = rd_data_r;
  assign rd_valid = rd_valid_r;
  assign trim_copy = trim_copy_r;
  assign conv_start = conv_start_r;
  assign results_latch = latch_r;
  assign continuous_mode = cont_r;
  assign fifo_flush = flush_r;

endmodule : sensor_boot_reset_oneshot_ctrl

`default_nettype wire
